// file: dv/dfp_monitor.sv
// Checker for the task-file link between the controller end and the drive end.
// Assumes the link is sampled on hclk and instantiated beside the interface.
`default_nettype none
module dfp_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [2:0] addr,
	input wire logic wr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata
);
	logic [8:0] run;
	logic [2:0] prev_addr;
	wire dw = wr && addr == dfp_pkg::SEL_DATA;
	wire cw = wr && addr == dfp_pkg::SEL_CMD;
	wire st_rd = prev_addr == dfp_pkg::SEL_CMD;
	// Counts the data-port writes of the block now being sent and keeps the select of the last edge.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run <= 9'h0;
			prev_addr <= dfp_pkg::SEL_CMD;
		end else begin
			run <= dw ? run + 9'h1 : 9'h0;
			prev_addr <= addr;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	cmd_pulse_a: assert property (cw |=> !wr)
		else $error("command strobe longer than one cycle");
	sel_first_a: assert property (cw |-> $past(wr) && $past(addr) == dfp_pkg::SEL_DH)
		else $error("command sent without drive select just before");
	err_idle_a: assert property (($past(addr) == dfp_pkg::SEL_CMD && rdata[0]) |-> !rdata[7])
		else $error("error reported while still busy");
	busy_nowr_a: assert property ((st_rd && !$past(wr) && rdata[7] && !rdata[3]) |-> !wr ##1 !wr)
		else $error("write issued while drive busy");
	blk_len_a: assert property ((run != 9'h0 && !dw) |-> run == 9'h100)
		else $error("password block not 256 words");
	ctl_word_a: assert property ((dw && run == 9'h0) |-> wdata[15:1] == 15'h0)
		else $error("control word reserved bits set");
	resv_zero_a: assert property ((dw && run > 9'h10) |-> wdata == 16'h0)
		else $error("reserved block word not zero");
	fault_code_a: assert property (($past(addr) == dfp_pkg::SEL_FAULT) |-> rdata inside {16'h0, 16'h4, 16'h40})
		else $error("unexpected fault code");
endmodule
`default_nettype wire

// file: dv/dfp_tb_top.sv
// Bench joining the controller end and the drive end over the task-file link.
// Assumes one 10 MHz clock; software reaches the controller over AHB-Lite.
`default_nettype none
module dfp_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cache_push = 1'b0, media_done = 1'b0, media_ok = 1'b0;
	logic lock_set = 1'b0, freeze_set = 1'b0, pw_load = 1'b0, pw_master = 1'b0, hd_valid = 1'b0, fail_en = 1'b0;
	logic irq, hreadyout, media_req, user_pw_valid, barred, fixed, hd_check_valid, full;
	logic [1:0] htrans = 2'h0;
	logic [3:0] pw_index = 4'h0;
	logic [7:0] hd_byte = 8'h0, hd_check, sum, got = 8'h0;
	logic [15:0] pw_word = 16'h0;
	logic [27:0] cache_push_addr = 28'h0, media_addr, last;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, st;
	int n_errors = 0, cmp_count = 0, tries = 0, writes = 0, t0, w0;
	logic [18:0] rows [4] = '{{2'h0, dfp_pkg::OP_FLUSH, 1'b0, 8'h0}, {2'h0, 8'h00, 1'b1, dfp_pkg::FAULT_REJECTED},
		{2'h0, dfp_pkg::OP_RELEASE, 1'b1, dfp_pkg::FAULT_REJECTED}, {2'h2, dfp_pkg::OP_RELEASE, 1'b0, 8'h0}};
	dfp_tf_if tf ();
	dfp_host u_dfp_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .irq(irq),
		.tf(tf.host));
	dfp_device u_dfp_device (.hclk(hclk), .hresetn(hresetn), .tf(tf.dev), .cache_push(cache_push),
		.cache_push_addr(cache_push_addr), .cache_full(full), .media_req(media_req), .media_addr(media_addr),
		.media_done(media_done), .media_ok(media_ok), .lock_set(lock_set), .freeze_set(freeze_set), .pw_load(pw_load),
		.pw_master(pw_master), .pw_index(pw_index), .pw_word(pw_word), .access_barred_state(barred),
		.security_settings_fixed_state(fixed), .user_pw_valid(user_pw_valid), .hd_valid(hd_valid), .hd_byte(hd_byte),
		.hd_check(hd_check), .hd_check_valid(hd_check_valid));
	dfp_monitor u_dfp_monitor (.hclk(hclk), .hresetn(hresetn), .addr(tf.addr), .wr(tf.wr), .wdata(tf.wdata),
		.rdata(tf.rdata));
	// Makes the 100 ns clock.
	initial begin
		forever #50 hclk = ~hclk;
	end
	// Media side answers each write a cycle later and keeps the page checksum it sees.
	always @(posedge hclk) begin
		media_done <= media_req && !media_done;
		media_ok <= !fail_en;
		if (hd_check_valid === 1'b1) got <= hd_check;
		if (media_done) begin
			tries <= tries + 1;
			writes <= writes + int'(media_ok);
			last <= media_addr;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task ahb(input logic w, input logic [5:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {26'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task cmd(input logic [1:0] ctl, input logic [7:0] op);
		ahb(1'b1, dfp_pkg::HOFF_CTRL, {30'h0, ctl});
		ahb(1'b1, dfp_pkg::HOFF_CMD, {24'h0, op});
		for (int k = 0; k < 5000 && irq !== 1'b1; k++) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		ahb(1'b0, dfp_pkg::HOFF_STATUS, 32'h0);
		st = r;
		chk({31'h0, st[0]}, 32'h0);
		ahb(1'b1, dfp_pkg::HOFF_IRQ_CLEAR, 32'h3);
	endtask
	task load(input logic m, input logic [15:0] base);
		for (int i = 0; i < 16; i++) begin
			pw_load <= 1'b1;
			pw_master <= m;
			pw_index <= 4'(i);
			pw_word <= base + 16'(i);
			@(posedge hclk);
		end
		pw_load <= 1'b0;
		@(posedge hclk);
	endtask
	task buf_pw(input logic [15:0] base, input logic [15:0] bad);
		ahb(1'b1, dfp_pkg::HOFF_PW_INDEX, 32'h0);
		for (int i = 0; i < 16; i++) ahb(1'b1, dfp_pkg::HOFF_PW_DATA, {16'h0, base + 16'(i) ^ (i == 5 ? bad : 16'h0)});
	endtask
	task pulse_push(input logic [27:0] a);
		cache_push <= 1'b1;
		cache_push_addr <= a;
		@(posedge hclk);
		cache_push <= 1'b0;
		@(posedge hclk);
	endtask
	task reset_run();
		hresetn <= 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b1, dfp_pkg::HOFF_IRQ_ENABLE, 32'h3);
	endtask
	task complete_run();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		repeat (60000) @(posedge hclk);
		n_errors++;
		complete_run();
	end
	// Main sequence: reset, table of commands, then the awkward cases.
	initial begin
		reset_run();
		ahb(1'b0, dfp_pkg::HOFF_IRQ_STATUS, 32'h0);
		chk(r, 32'h0);
		ahb(1'b0, 6'h3c, 32'h0);
		chk(r, 32'h0);
		foreach (rows[i]) begin
			cmd(rows[i][18:17], rows[i][16:9]);
			chk({31'h0, st[8]}, {31'h0, rows[i][8]});
			if (rows[i][8]) chk({24'h0, st[23:16]}, {24'h0, rows[i][7:0]});
		end
		sum = 8'h0;
		for (int i = 0; i < 511; i++) begin
			hd_valid <= 1'b1;
			hd_byte <= 8'(i * 3 + 1);
			sum = sum + 8'(i * 3 + 1);
			@(posedge hclk);
		end
		hd_valid <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({24'h0, got}, {24'h0, 8'h0 - sum});
		pulse_push(28'h1234567);
		pulse_push(28'h0abcdef);
		fail_en <= 1'b1;
		t0 = tries;
		cmd(2'h0, dfp_pkg::OP_FLUSH);
		chk(st[23:8], {dfp_pkg::FAULT_WRITE, 8'h41});
		chk(tries - t0, 3);
		ahb(1'b0, dfp_pkg::HOFF_FAIL, 32'h0);
		chk(r, 32'h01234567);
		fail_en <= 1'b0;
		w0 = writes;
		cmd(2'h0, dfp_pkg::OP_FLUSH);
		chk(writes - w0, 1);
		chk({4'h0, last}, 32'h0abcdef);
		pulse_push(28'h0000042);
		w0 = writes;
		cmd(2'h1, dfp_pkg::OP_FLUSH);
		chk(writes - w0, 0);
		cmd(2'h0, dfp_pkg::OP_FLUSH);
		chk(writes - w0, 1);
		load(1'b1, 16'h1000);
		load(1'b0, 16'h2000);
		buf_pw(16'h1000, 16'h0001);
		cmd(2'h2, dfp_pkg::OP_RELEASE);
		chk({st[23:16], 7'h0, st[8], 7'h0, user_pw_valid}, 32'h00040101);
		buf_pw(16'h1000, 16'h0);
		cmd(2'h2, dfp_pkg::OP_RELEASE);
		chk({st[8], user_pw_valid, barred}, 32'h0);
		cmd(2'h2, dfp_pkg::OP_RELEASE);
		chk({31'h0, st[8]}, 32'h0);
		freeze_set <= 1'b1;
		@(posedge hclk);
		freeze_set <= 1'b0;
		cmd(2'h2, dfp_pkg::OP_RELEASE);
		chk({st[8], fixed}, 32'h3);
		reset_run();
		chk({31'h0, fixed}, 32'h0);
		load(1'b1, 16'h1000);
		buf_pw(16'h1000, 16'h0);
		lock_set <= 1'b1;
		@(posedge hclk);
		lock_set <= 1'b0;
		cmd(2'h2, dfp_pkg::OP_RELEASE);
		chk({st[23:16], 7'h0, st[8], 7'h0, barred}, 32'h00040101);
		ahb(1'b1, dfp_pkg::HOFF_IRQ_ENABLE, 32'h0);
		ahb(1'b1, dfp_pkg::HOFF_CMD, 32'h0);
		r = 32'h0;
		for (int k = 0; k < 200 && r[0] !== 1'b1; k++) ahb(1'b0, dfp_pkg::HOFF_IRQ_STATUS, 32'h0);
		chk({r[30:0], irq}, 32'h6);
		ahb(1'b1, dfp_pkg::HOFF_IRQ_ENABLE, 32'h3);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		ahb(1'b1, dfp_pkg::HOFF_IRQ_CLEAR, 32'h3);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		// The cache reports full once the slot at the write pointer holds an unflushed entry; filling from reset, that takes all eight slots.
		for (int i = 0; i < 7; i++) pulse_push(28'(i));
		chk({31'h0, full}, 32'h0);
		pulse_push(28'h0000007);
		chk({31'h0, full}, 32'h1);
		complete_run();
	end
endmodule
`default_nettype wire

// file: rtl/dfp_device.sv
// Drive end: task-file registers, cache flush, lock release, page checksum.
// Assumes the controller end on the link and a media writer on the user side.
`default_nettype none
// Operation
// - Page last byte negates sum of 511
// - Opcode E7 starts a cache flush
// - Every cached item written before success
// - Busy held until flush ends
// - Retry each failed media write
// - Controller never times out a flush
// - Unsupported flush sets rejected flag
// - Unrecoverable write loads failing sector address
// - Failed sector dropped, next flush resumes
// - Opcode F6 starts lock release
// - Controller sends 512-byte password block
// - Match releases lock, invalidates user password
// - Master password never changed by release
// - Mismatch ends with rejected flag
// - Locked or frozen rejects release
// - Word 0 bit 0 selects password
// - Reserved bits and words ignored
// - Frozen lasts until power removed
module dfp_device #(
	parameter bit DRIVE_NUM = 1'b0,
	parameter bit FLUSH_SUPPORTED = 1'b1
) (
	input wire logic hclk,
	input wire logic hresetn,
	dfp_tf_if.dev tf,
	input wire logic cache_push,
	input wire logic [dfp_pkg::LBA_W-1:0] cache_push_addr,
	output logic cache_full,
	output logic media_req,
	output logic [dfp_pkg::LBA_W-1:0] media_addr,
	input wire logic media_done,
	input wire logic media_ok,
	input wire logic lock_set,
	input wire logic freeze_set,
	input wire logic pw_load,
	input wire logic pw_master,
	input wire logic [3:0] pw_index,
	input wire logic [15:0] pw_word,
	output logic access_barred_state,
	output logic security_settings_fixed_state,
	output logic user_pw_valid,
	input wire logic hd_valid,
	input wire logic [7:0] hd_byte,
	output logic [7:0] hd_check,
	output logic hd_check_valid
);
	dfp_pkg::dfp_dev_state_type state;
	logic [7:0] status;
	logic [7:0] fault;
	logic [7:0] sc, sn, cl, ch, dh;
	logic [dfp_pkg::LBA_W-1:0] cache_addr [dfp_pkg::CACHE_DEPTH];
	logic [dfp_pkg::CACHE_DEPTH-1:0] cache_valid;
	logic [2:0] wptr, scan_idx;
	logic [3:0] scan_cnt;
	logic [1:0] tries;
	logic [7:0] word_cnt;
	logic sel_master, mismatch;
	logic [15:0] user_pw [dfp_pkg::PW_WORDS];
	logic [15:0] master_pw [dfp_pkg::PW_WORDS];
	logic [8:0] hd_cnt;
	logic [7:0] hd_sum;

	// Command decode, drive match and data-port acceptance.
	wire idle_regs = !status[dfp_pkg::ST_BSY] && !status[dfp_pkg::ST_DRQ];
	wire reg_wr = tf.wr && idle_regs;
	wire drive_select_bit = dh[dfp_pkg::DH_DRIVE_BIT];
	wire cmd_go = reg_wr && tf.addr == dfp_pkg::SEL_CMD && drive_select_bit == DRIVE_NUM;
	wire [7:0] opcode = tf.wdata[7:0];
	wire start_flush = opcode == dfp_pkg::OP_FLUSH && FLUSH_SUPPORTED;
	wire start_release = opcode == dfp_pkg::OP_RELEASE;
	wire release_barred = access_barred_state || security_settings_fixed_state;
	wire data_wr = tf.wr && tf.addr == dfp_pkg::SEL_DATA && state == dfp_pkg::DEV_RECV;
	wire pw_in_range = word_cnt != 8'h00 && word_cnt <= dfp_pkg::PW_LAST_WORD;
	wire [3:0] pw_idx = 4'(word_cnt - 8'h01);
	wire [15:0] pw_ref = sel_master ? master_pw[pw_idx] : user_pw[pw_idx];
	wire pw_bad = mismatch || (!sel_master && !user_pw_valid);
	wire release_ok = state == dfp_pkg::DEV_CHECK && !pw_bad;

	// Media outcome decode; the last allowed retry failing is unrecoverable.
	wire media_back = state == dfp_pkg::DEV_WAIT && media_done;
	wire fail_load = media_back && !media_ok && tries == dfp_pkg::RETRY_LIMIT - 2'h1;
	wire entry_drop = media_back && (media_ok || fail_load);
	wire push_ok = cache_push && !cache_full;
	wire [dfp_pkg::LBA_W-1:0] fail_addr = cache_addr[scan_idx];
	assign cache_full = cache_valid[wptr];

	// Read selection of the task-file registers.
	wire [7:0] rd_byte = tf.addr == dfp_pkg::SEL_FAULT ? fault :
		tf.addr == dfp_pkg::SEL_SC ? sc :
		tf.addr == dfp_pkg::SEL_SN ? sn :
		tf.addr == dfp_pkg::SEL_CL ? cl :
		tf.addr == dfp_pkg::SEL_CH ? ch :
		tf.addr == dfp_pkg::SEL_DH ? dh :
		tf.addr == dfp_pkg::SEL_CMD ? status : 8'h00;

	// Read data is registered one edge after the address.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tf.rdata <= 16'h0000;
		end else begin
			tf.rdata <= {8'h00, rd_byte};
		end
	end

	// Command sequencer for flush and lock release.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= dfp_pkg::DEV_IDLE;
			status <= dfp_pkg::STATUS_RESET;
			fault <= 8'h00;
			scan_idx <= 3'h0;
			scan_cnt <= 4'h0;
			tries <= 2'h0;
			media_req <= 1'b0;
			media_addr <= '0;
			word_cnt <= 8'h00;
			sel_master <= 1'b0;
			mismatch <= 1'b0;
		end else begin
			unique case (state)
				dfp_pkg::DEV_IDLE: begin
					if (cmd_go && start_flush) begin
						status[dfp_pkg::ST_BSY] <= 1'b1;
						status[dfp_pkg::ST_ERR] <= 1'b0;
						fault <= 8'h00;
						scan_idx <= 3'h0;
						scan_cnt <= 4'h0;
						tries <= 2'h0;
						state <= dfp_pkg::DEV_SCAN;
					end else if (cmd_go && start_release && !release_barred) begin
						status[dfp_pkg::ST_DRQ] <= 1'b1;
						status[dfp_pkg::ST_ERR] <= 1'b0;
						fault <= 8'h00;
						word_cnt <= 8'h00;
						mismatch <= 1'b0;
						state <= dfp_pkg::DEV_RECV;
					end else if (cmd_go) begin
						status[dfp_pkg::ST_ERR] <= 1'b1;
						fault <= dfp_pkg::FAULT_REJECTED;
					end
				end
				dfp_pkg::DEV_SCAN: begin
					if (scan_cnt == dfp_pkg::CACHE_COUNT) begin
						status[dfp_pkg::ST_BSY] <= 1'b0;
						state <= dfp_pkg::DEV_IDLE;
					end else if (cache_valid[scan_idx]) begin
						media_req <= 1'b1;
						media_addr <= cache_addr[scan_idx];
						state <= dfp_pkg::DEV_WAIT;
					end else begin
						scan_idx <= scan_idx + 3'h1;
						scan_cnt <= scan_cnt + 4'h1;
					end
				end
				dfp_pkg::DEV_WAIT: begin
					if (media_done) begin
						media_req <= 1'b0;
						if (media_ok) begin
							scan_idx <= scan_idx + 3'h1;
							scan_cnt <= scan_cnt + 4'h1;
							tries <= 2'h0;
							state <= dfp_pkg::DEV_SCAN;
						end else if (fail_load) begin
							status[dfp_pkg::ST_BSY] <= 1'b0;
							status[dfp_pkg::ST_ERR] <= 1'b1;
							fault <= dfp_pkg::FAULT_WRITE;
							state <= dfp_pkg::DEV_IDLE;
						end else begin
							tries <= tries + 2'h1;
							state <= dfp_pkg::DEV_SCAN;
						end
					end
				end
				dfp_pkg::DEV_RECV: begin
					if (data_wr) begin
						word_cnt <= word_cnt + 8'h01;
						if (word_cnt == 8'h00) begin
							sel_master <= tf.wdata[0];
						end
						if (pw_in_range && tf.wdata != pw_ref) begin
							mismatch <= 1'b1;
						end
						if (word_cnt == dfp_pkg::BLOCK_LAST) begin
							status[dfp_pkg::ST_DRQ] <= 1'b0;
							status[dfp_pkg::ST_BSY] <= 1'b1;
							state <= dfp_pkg::DEV_CHECK;
						end
					end
				end
				dfp_pkg::DEV_CHECK: begin
					status[dfp_pkg::ST_BSY] <= 1'b0;
					status[dfp_pkg::ST_ERR] <= pw_bad;
					fault <= pw_bad ? dfp_pkg::FAULT_REJECTED : 8'h00;
					state <= dfp_pkg::DEV_IDLE;
				end
			endcase
		end
	end

	// Address registers: a failed flush loads the failing sector address.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sc <= 8'h00;
			sn <= 8'h00;
			cl <= 8'h00;
			ch <= 8'h00;
			dh <= 8'h00;
		end else if (fail_load) begin
			sn <= fail_addr[7:0];
			cl <= fail_addr[15:8];
			ch <= fail_addr[23:16];
			dh[3:0] <= fail_addr[27:24];
		end else if (reg_wr) begin
			if (tf.addr == dfp_pkg::SEL_SC) sc <= tf.wdata[7:0];
			if (tf.addr == dfp_pkg::SEL_SN) sn <= tf.wdata[7:0];
			if (tf.addr == dfp_pkg::SEL_CL) cl <= tf.wdata[7:0];
			if (tf.addr == dfp_pkg::SEL_CH) ch <= tf.wdata[7:0];
			if (tf.addr == dfp_pkg::SEL_DH) dh <= tf.wdata[7:0];
		end
	end

	// Write cache: filled at the write pointer, entries dropped once flushed or failed.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cache_valid <= '0;
			wptr <= 3'h0;
			for (int i = 0; i < dfp_pkg::CACHE_DEPTH; i++) cache_addr[i] <= '0;
		end else begin
			for (int i = 0; i < dfp_pkg::CACHE_DEPTH; i++) begin
				if (entry_drop && scan_idx == 3'(i)) cache_valid[i] <= 1'b0;
				if (push_ok && wptr == 3'(i)) cache_valid[i] <= 1'b1;
			end
			if (push_ok) begin
				cache_addr[wptr] <= cache_push_addr;
				wptr <= wptr + 3'h1;
			end
		end
	end

	// Security state; a set that meets a release in one cycle wins.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			access_barred_state <= 1'b0;
			security_settings_fixed_state <= 1'b0;
			user_pw_valid <= 1'b0;
		end else begin
			access_barred_state <= lock_set || (access_barred_state && !release_ok);
			security_settings_fixed_state <= security_settings_fixed_state || freeze_set;
			user_pw_valid <= (pw_load && !pw_master) || (user_pw_valid && !release_ok);
		end
	end

	// Stored passwords; release never writes the master copy.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < dfp_pkg::PW_WORDS; i++) begin
				user_pw[i] <= 16'h0000;
				master_pw[i] <= 16'h0000;
			end
		end else if (pw_load && pw_master) begin
			master_pw[pw_index] <= pw_word;
		end else if (pw_load) begin
			user_pw[pw_index] <= pw_word;
		end
	end

	// Health page checksum over the first 511 bytes of each page.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hd_cnt <= 9'h000;
			hd_sum <= 8'h00;
			hd_check <= 8'h00;
			hd_check_valid <= 1'b0;
		end else begin
			hd_check_valid <= 1'b0;
			if (hd_valid && hd_cnt == dfp_pkg::PAGE_LAST) begin
				hd_check <= 8'h00 - (hd_sum + hd_byte);
				hd_check_valid <= 1'b1;
				hd_cnt <= 9'h000;
				hd_sum <= 8'h00;
			end else if (hd_valid) begin
				hd_cnt <= hd_cnt + 9'h001;
				hd_sum <= hd_sum + hd_byte;
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/dfp_host.sv
// Controller end: AHB-Lite registers in, task-file command sequences out.
// Assumes a zero-wait AHB-Lite master and the drive end on the link.
`default_nettype none
module dfp_host (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq,
	dfp_tf_if.host tf
);
	dfp_pkg::dfp_host_state_type state;
	logic dph_valid, dph_write;
	logic [5:0] dph_addr;
	logic ctrl_drive, ctrl_master;
	logic [15:0] pw_buf [dfp_pkg::PW_WORDS];
	logic [3:0] pw_ptr;
	logic [1:0] irq_status, irq_enable;
	logic [7:0] opcode, res_status, res_fault;
	logic [dfp_pkg::LBA_W-1:0] fail_addr;
	logic [2:0] rd_idx;
	logic [7:0] word_cnt;

	// Bus decode; every transfer completes with no wait and OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	wire aph = hsel && htrans[1] && hready;
	wire dph_wr = dph_valid && dph_write;
	wire busy = state != dfp_pkg::H_IDLE;
	wire start = dph_wr && dph_addr == dfp_pkg::HOFF_CMD && !busy;
	wire finish = state == dfp_pkg::H_FINISH;
	wire [1:0] irq_set = {finish && res_status[dfp_pkg::ST_ERR], finish};
	wire [1:0] irq_clr = dph_wr && dph_addr == dfp_pkg::HOFF_IRQ_CLEAR ? hwdata[1:0] : 2'h0;
	assign irq = |(irq_status & irq_enable);
	wire [5:0] ra = haddr[5:0];
	wire [31:0] rd_word = ra == dfp_pkg::HOFF_CTRL ? {30'h0, ctrl_master, ctrl_drive} :
		ra == dfp_pkg::HOFF_STATUS ? {8'h00, res_fault, res_status, 7'h00, busy} :
		ra == dfp_pkg::HOFF_FAIL ? {4'h0, fail_addr} :
		ra == dfp_pkg::HOFF_IRQ_STATUS ? {30'h0, irq_status} :
		ra == dfp_pkg::HOFF_IRQ_ENABLE ? {30'h0, irq_enable} : 32'h0000_0000;

	// Password block word: control word, 16 password words, then zeros.
	wire [15:0] tx_word = word_cnt == 8'h00 ? {15'h0000, ctrl_master} :
		word_cnt <= dfp_pkg::PW_LAST_WORD ? pw_buf[4'(word_cnt - 8'h01)] : 16'h0000;

	// Task-file read sequence: status, fault, then the failing address.
	wire [2:0] rd_sel = rd_idx == 3'h0 ? dfp_pkg::SEL_CMD :
		rd_idx == 3'h1 ? dfp_pkg::SEL_FAULT :
		rd_idx == 3'h2 ? dfp_pkg::SEL_SN :
		rd_idx == 3'h3 ? dfp_pkg::SEL_CL :
		rd_idx == 3'h4 ? dfp_pkg::SEL_CH : dfp_pkg::SEL_DH;
	wire [7:0] rb = tf.rdata[7:0];

	// Address phase capture and registered read data.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_valid <= 1'b0;
			dph_write <= 1'b0;
			dph_addr <= 6'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			dph_valid <= aph;
			dph_write <= hwrite;
			dph_addr <= haddr[5:0];
			if (aph && !hwrite) hrdata <= rd_word;
		end
	end

	// Software-written registers; an interrupt set wins over its clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_drive <= 1'b0;
			ctrl_master <= 1'b0;
			pw_ptr <= 4'h0;
			irq_enable <= 2'h0;
			irq_status <= 2'h0;
			for (int i = 0; i < dfp_pkg::PW_WORDS; i++) pw_buf[i] <= 16'h0000;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
			if (dph_wr && dph_addr == dfp_pkg::HOFF_CTRL) begin
				ctrl_drive <= hwdata[dfp_pkg::CTRL_DRIVE];
				ctrl_master <= hwdata[dfp_pkg::CTRL_MASTER];
			end
			if (dph_wr && dph_addr == dfp_pkg::HOFF_IRQ_ENABLE) irq_enable <= hwdata[1:0];
			if (dph_wr && dph_addr == dfp_pkg::HOFF_PW_INDEX) pw_ptr <= hwdata[3:0];
			if (dph_wr && dph_addr == dfp_pkg::HOFF_PW_DATA) begin
				pw_buf[pw_ptr] <= hwdata[15:0];
				pw_ptr <= pw_ptr + 4'h1;
			end
		end
	end

	// Command sequencer driving the task-file link.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= dfp_pkg::H_IDLE;
			tf.addr <= dfp_pkg::SEL_CMD;
			tf.wr <= 1'b0;
			tf.wdata <= 16'h0000;
			opcode <= 8'h00;
			res_status <= 8'h00;
			res_fault <= 8'h00;
			fail_addr <= '0;
			rd_idx <= 3'h0;
			word_cnt <= 8'h00;
		end else begin
			unique case (state)
				dfp_pkg::H_IDLE: begin
					if (start) begin
						opcode <= hwdata[7:0];
						state <= dfp_pkg::H_SEL;
					end
				end
				dfp_pkg::H_SEL: begin
					tf.addr <= dfp_pkg::SEL_DH;
					tf.wdata <= {11'h000, ctrl_drive, 4'h0};
					tf.wr <= 1'b1;
					state <= dfp_pkg::H_CMD;
				end
				dfp_pkg::H_CMD: begin
					tf.addr <= dfp_pkg::SEL_CMD;
					tf.wdata <= {8'h00, opcode};
					tf.wr <= 1'b1;
					rd_idx <= 3'h0;
					state <= dfp_pkg::H_RD_SET;
				end
				dfp_pkg::H_RD_SET: begin
					tf.wr <= 1'b0;
					tf.addr <= rd_sel;
					state <= dfp_pkg::H_RD_WAIT;
				end
				dfp_pkg::H_RD_WAIT: state <= dfp_pkg::H_RD_TAKE;
				dfp_pkg::H_RD_TAKE: begin
					state <= dfp_pkg::H_RD_SET;
					unique case (rd_idx)
						3'h0: begin
							res_status <= rb;
							if (rb[dfp_pkg::ST_BSY]) begin
								rd_idx <= 3'h0;
							end else if (rb[dfp_pkg::ST_DRQ]) begin
								word_cnt <= 8'h00;
								state <= dfp_pkg::H_DATA;
							end else if (rb[dfp_pkg::ST_ERR]) begin
								rd_idx <= 3'h1;
							end else begin
								res_fault <= 8'h00;
								state <= dfp_pkg::H_FINISH;
							end
						end
						3'h1: begin
							res_fault <= rb;
							rd_idx <= 3'h2;
							if (rb != dfp_pkg::FAULT_WRITE) state <= dfp_pkg::H_FINISH;
						end
						3'h2: begin
							fail_addr[7:0] <= rb;
							rd_idx <= 3'h3;
						end
						3'h3: begin
							fail_addr[15:8] <= rb;
							rd_idx <= 3'h4;
						end
						3'h4: begin
							fail_addr[23:16] <= rb;
							rd_idx <= 3'h5;
						end
						default: begin
							fail_addr[27:24] <= rb[3:0];
							state <= dfp_pkg::H_FINISH;
						end
					endcase
				end
				dfp_pkg::H_DATA: begin
					tf.addr <= dfp_pkg::SEL_DATA;
					tf.wdata <= tx_word;
					tf.wr <= 1'b1;
					word_cnt <= word_cnt + 8'h01;
					if (word_cnt == dfp_pkg::BLOCK_LAST) begin
						rd_idx <= 3'h0;
						state <= dfp_pkg::H_RD_SET;
					end
				end
				dfp_pkg::H_FINISH: begin
					tf.wr <= 1'b0;
					state <= dfp_pkg::H_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: rtl/dfp_pkg.sv
// Shared constants and types for the flush and lock-release command ends.
// Assumes a single clock domain and the task-file port as the only link.
`default_nettype none
package dfp_pkg;
	// Task-file port offsets and their three-bit selectors.
	localparam logic [11:0] OFF_DATA = 12'h1f0;
	localparam logic [11:0] OFF_FEATURE_FAULT = 12'h1f1;
	localparam logic [11:0] OFF_SECTOR_COUNT = 12'h1f2;
	localparam logic [11:0] OFF_SECTOR_NUMBER = 12'h1f3;
	localparam logic [11:0] OFF_CYLINDER_LOW = 12'h1f4;
	localparam logic [11:0] OFF_CYLINDER_HIGH = 12'h1f5;
	localparam logic [11:0] OFF_DRIVE_HEAD = 12'h1f6;
	localparam logic [11:0] OFF_COMMAND_CONDITION = 12'h1f7;
	localparam logic [2:0] SEL_DATA = OFF_DATA[2:0];
	localparam logic [2:0] SEL_FAULT = OFF_FEATURE_FAULT[2:0];
	localparam logic [2:0] SEL_SC = OFF_SECTOR_COUNT[2:0];
	localparam logic [2:0] SEL_SN = OFF_SECTOR_NUMBER[2:0];
	localparam logic [2:0] SEL_CL = OFF_CYLINDER_LOW[2:0];
	localparam logic [2:0] SEL_CH = OFF_CYLINDER_HIGH[2:0];
	localparam logic [2:0] SEL_DH = OFF_DRIVE_HEAD[2:0];
	localparam logic [2:0] SEL_CMD = OFF_COMMAND_CONDITION[2:0];
	// Status and fault bit positions, reset value and opcodes.
	localparam int ST_BSY = 7;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	localparam logic [7:0] STATUS_RESET = 8'h40;
	localparam logic [7:0] FAULT_REJECTED = 8'h04;
	localparam logic [7:0] FAULT_WRITE = 8'h40;
	localparam int DH_DRIVE_BIT = 4;
	localparam logic [7:0] OP_FLUSH = 8'he7;
	localparam logic [7:0] OP_RELEASE = 8'hf6;
	// Cache, password block and health page sizes.
	localparam int CACHE_DEPTH = 8;
	localparam logic [3:0] CACHE_COUNT = 4'h8;
	localparam int LBA_W = 28;
	localparam logic [1:0] RETRY_LIMIT = 2'h3;
	localparam int PW_WORDS = 16;
	localparam logic [7:0] PW_LAST_WORD = 8'h10;
	localparam logic [7:0] BLOCK_LAST = 8'hff;
	localparam logic [8:0] PAGE_LAST = 9'h1fe;
	// Controller register offsets, control and interrupt bits.
	localparam logic [5:0] HOFF_CTRL = 6'h00;
	localparam logic [5:0] HOFF_CMD = 6'h04;
	localparam logic [5:0] HOFF_STATUS = 6'h08;
	localparam logic [5:0] HOFF_FAIL = 6'h0c;
	localparam logic [5:0] HOFF_PW_DATA = 6'h10;
	localparam logic [5:0] HOFF_PW_INDEX = 6'h14;
	localparam logic [5:0] HOFF_IRQ_STATUS = 6'h18;
	localparam logic [5:0] HOFF_IRQ_CLEAR = 6'h1c;
	localparam logic [5:0] HOFF_IRQ_ENABLE = 6'h20;
	localparam int CTRL_DRIVE = 0;
	localparam int CTRL_MASTER = 1;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERROR = 1;
	typedef enum logic [2:0] {DEV_IDLE, DEV_SCAN, DEV_WAIT, DEV_RECV, DEV_CHECK} dfp_dev_state_type;
	typedef enum logic [2:0] {H_IDLE, H_SEL, H_CMD, H_RD_SET, H_RD_WAIT, H_RD_TAKE, H_DATA, H_FINISH} dfp_host_state_type;
endpackage
`default_nettype wire

// file: rtl/dfp_tf_if.sv
// Task-file link between the controller end and the drive end.
// Assumes both ends share hclk; rdata follows addr one edge later.
`default_nettype none
interface dfp_tf_if;
	logic [2:0] addr;
	logic wr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport host (output addr, output wr, output wdata, input rdata);
	modport dev (input addr, input wr, input wdata, output rdata);
endinterface
`default_nettype wire
